// [core/nfc_pkg.sv]
// Shared constants and types for the NAND host sequencer
package nfc_pkg;
  // Timing, as printed, and derived cycle counts at 25 MHz
  localparam int CLK_NS = 40;
  localparam int T_ADL_NS = 70;
  localparam int T_REA_NS = 16;
  localparam int SYNC_STAGES = 2;
  localparam logic [2:0] ADL_CYC = 3'((T_ADL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] RD_CYC =
    3'((T_REA_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  // Wait before trusting the ready/busy pin after a confirm
  localparam logic [2:0] WB_CYC = 3'd4;
  localparam int SR_READY_BIT = 6;
  // Opcodes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_PLANE_NEXT = 8'h11;
  localparam logic [7:0] CMD_CACHE_GO = 8'h15;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_ERASE_NEXT = 8'hD1;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  // Feature space
  localparam logic [7:0] FEAT_ARRAY_MODE = 8'h90;
  localparam logic [7:0] MODE_NORMAL = 8'h00;
  localparam logic [7:0] MODE_OTP = 8'h01;
  localparam logic [7:0] MODE_OTP_PROT = 8'h03;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] OTP_NOP_MAX = 4'h8;
  // Register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR0 = 8'h04;
  localparam logic [7:0] REG_ADDR1 = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [31:0] CMD_MASK = 32'h07FF_FFFF;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [4:0] rsv;
    logic poll;
    logic has2;
    logic has1;
    logic wait_busy;
    logic dir;
    logic [2:0] dc;
    logic [2:0] ac;
    logic [7:0] cmd2;
    logic [7:0] cmd1;
  } nfc_cmd_t;
endpackage

// [core/nfc_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module nfc_sync #(
  parameter int W = 1
) (
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      q <= s1;
    end
  end
endmodule
`default_nettype wire

// [core/nfc_regs.sv]
// APB register file of the NAND host sequencer
`timescale 1ns/10ps
`default_nettype none
module nfc_regs
  import nfc_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Engine side
  input wire logic busy,
  input wire logic [31:0] rdata,
  input wire logic [31:0] stat_word,
  output nfc_cmd_t cmd,
  output logic [39:0] addr,
  output logic [31:0] wdata,
  output logic launch
);
  wire setup = psel && !penable;
  wire wr = psel && penable && pready && pwrite;
  // Operands freeze while an operation runs
  wire wr_ok = wr && !busy;
  wire sel_cmd = paddr == REG_CMD;
  wire sel_a0 = paddr == REG_ADDR0;
  wire sel_a1 = paddr == REG_ADDR1;
  wire sel_wd = paddr == REG_WDATA;
  wire sel_rd = paddr == REG_RDATA;
  wire sel_st = paddr == REG_STAT;
  wire hit = sel_cmd || sel_a0 || sel_a1 || sel_wd || sel_rd || sel_st;
  wire [31:0] rd_mux = sel_cmd ? cmd :
                       sel_a0 ? addr[31:0] :
                       sel_a1 ? {24'h000000, addr[39:32]} :
                       sel_wd ? wdata :
                       sel_rd ? rdata :
                       sel_st ? stat_word : RST_WORD;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cmd <= nfc_cmd_t'(RST_WORD);
      addr <= 40'h00_0000_0000;
      wdata <= RST_WORD;
      launch <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup)
        prdata <= rd_mux;
      launch <= wr_ok && sel_cmd;
      if (wr_ok && sel_cmd)
        cmd <= nfc_cmd_t'(pwdata & CMD_MASK);
      if (wr_ok && sel_a0)
        addr[31:0] <= pwdata;
      if (wr_ok && sel_a1)
        addr[39:32] <= pwdata[7:0];
      if (wr_ok && sel_wd)
        wdata <= pwdata;
    end
  end
endmodule
`default_nettype wire

// [core/nfc_top.sv]
// NAND host sequencer: command engine driving the flash pins
// How it works
// - Feature write: EFh, feature address, four parameter bytes.
// - Feature read: EEh, feature address, then four bytes read back.
// - OTP entry writes 01h then three zero bytes to feature 90h.
// - Writing 00h to feature 90h returns to normal array access.
// - After polling 70h during a feature read, issue 00h first.
// - At most eight partial programs per OTP page.
// - Lock: feature 90h gets 03h, then 80h, address ending 00h, 10h.
// - Two planes: same operation, plane bit differs, page equal.
// - Block address bits of the two planes may differ.
// - Two-plane program: 80h-11h then 80h-10h, cache with 80h-15h.
// - Two-plane erase: 60h-D1h first block, 60h-D0h second.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module nfc_top
  import nfc_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // NAND control pins
  output logic nand_ce_n,
  output logic nand_cle,
  output logic nand_ale,
  output logic nand_we_n,
  output logic nand_re_n,
  input wire logic nand_rb_n,
  // NAND data bus
  output logic [7:0] nand_io_out,
  output logic nand_io_oe,
  input wire logic [7:0] nand_io_in
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_WDAT, S_CMD2, S_WB, S_WRB,
    S_PCMD, S_PRD, S_RESUME, S_RDAT, S_DONE
  } nfc_state_t;

  nfc_state_t state;
  logic ph;
  logic [2:0] cnt;
  logic [2:0] idx;
  logic busy;
  logic [31:0] rdata;
  logic [7:0] stat_byte;
  logic [7:0] mode;
  logic armed;
  logic arm_pl;
  logic arm_erase;
  logic [5:0] arm_page;
  logic otp_locked;
  logic [3:0] err;
  logic [3:0] otp_cnt [32];
  logic launch;
  logic rb_s;
  logic [7:0] io_s;
  nfc_cmd_t c;
  logic [39:0] c_addr;
  logic [31:0] c_wdata;
  logic [31:0] stat_word;

  nfc_regs u_regs (
    .clock(clock),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .busy(busy),
    .rdata(rdata),
    .stat_word(stat_word),
    .cmd(c),
    .addr(c_addr),
    .wdata(c_wdata),
    .launch(launch)
  );

  nfc_sync #(.W(1)) u_sync_rb (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(nand_rb_n),
    .q(rb_s)
  );

  nfc_sync #(.W(8)) u_sync_io (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(nand_io_in),
    .q(io_s)
  );

  // Byte selection for address and write data cycles
  wire [39:0] a_sh = c_addr >> {idx, 3'b000};
  wire [31:0] w_sh = c_wdata >> {idx[1:0], 3'b000};
  wire [2:0] ac_m1 = c.ac - 3'd1;
  wire [39:0] l_sh = c_addr >> {ac_m1, 3'b000};
  // Erase sends row bytes only; otherwise two column bytes lead
  wire [7:0] row1 = (c.ac == 3'd3) ? c_addr[7:0] : c_addr[23:16];

  // Launch checks
  wire is_sf90 = c.has1 && c.cmd1 == CMD_SET_FEAT && c.ac == 3'd1 &&
                 c_addr[7:0] == FEAT_ARRAY_MODE;
  wire p1_ok = c_wdata[7:0] == MODE_NORMAL || c_wdata[7:0] == MODE_OTP ||
               c_wdata[7:0] == MODE_OTP_PROT;
  wire sf_bad = is_sf90 && (!p1_ok || c_wdata[31:8] != 24'h000000);
  wire is_prog = c.has1 && c.cmd1 == CMD_PROG && c.has2 &&
                 c.cmd2 == CMD_PROG_GO;
  wire otp_pg_ok = !row1[5] && row1[4:1] != 4'h0;
  wire otp_bad = mode == MODE_OTP && is_prog && (otp_locked ||
                 !otp_pg_ok || otp_cnt[row1[4:0]] == OTP_NOP_MAX);
  wire prot_bad = mode == MODE_OTP_PROT && is_prog &&
                  (c.ac == 3'd0 || l_sh[7:0] != 8'h00);
  wire arm_er = c.cmd2 == CMD_ERASE_NEXT;
  wire arm = c.has2 && (c.cmd2 == CMD_PLANE_NEXT || arm_er);
  wire cl_er = c.cmd2 == CMD_ERASE_GO;
  wire close = armed && c.has2 && (c.cmd2 == CMD_PROG_GO ||
               c.cmd2 == CMD_CACHE_GO || cl_er);
  wire pair_bad = (arm && armed) || (close && (cl_er != arm_erase ||
                  row1[6] == arm_pl || (!cl_er && row1[5:0] != arm_page)));
  wire refuse = sf_bad || otp_bad || prot_bad || pair_bad;
  wire go = launch && !busy && !refuse;
  // Feature writes that wait for busy confirm through status polling
  wire use_poll = c.poll || (c.has1 && c.cmd1 == CMD_SET_FEAT);
  wire want_rd = c.dir && c.dc != 3'd0;
  assign stat_word = {stat_byte, 4'h0, err, mode, 5'h00,
                      otp_locked, armed, busy};

  // Shadow of the device's mode, OTP usage and plane pairing
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= MODE_RESET;
      armed <= 1'b0;
      arm_pl <= 1'b0;
      arm_erase <= 1'b0;
      arm_page <= 6'h00;
      otp_locked <= 1'b0;
      err <= 4'h0;
      for (int i = 0; i < 32; i++)
        otp_cnt[i] <= 4'h0;
    end else if (launch && !busy) begin
      err <= {pair_bad, prot_bad, otp_bad, sf_bad};
      if (!refuse) begin
        // Reset opcode never touches the shadow, like the device
        if (is_sf90)
          mode <= c_wdata[7:0];
        if (mode == MODE_OTP && is_prog)
          otp_cnt[row1[4:0]] <= otp_cnt[row1[4:0]] + 4'h1;
        if (mode == MODE_OTP_PROT && is_prog)
          otp_locked <= 1'b1;
        if (arm) begin
          armed <= 1'b1;
          arm_pl <= row1[6];
          arm_page <= row1[5:0];
          arm_erase <= arm_er;
        end else if (close) begin
          armed <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_cmd_cycle(logic [7:0] op);
    nand_cle && !nand_we_n && nand_io_out == op;
  endsequence

  a_feat_bad_param: assert property (
    launch && !busy && sf_bad |=> !busy && err[0] && state == S_IDLE)
    else $error("bad feature parameters were not refused");
  a_mode_exit: assert property (
    go && is_sf90 && c_wdata[7:0] == MODE_NORMAL |=> mode == MODE_NORMAL)
    else $error("mode shadow did not return to normal");
  a_otp_nop_limit: assert property (
    launch && !busy && mode == MODE_OTP && is_prog &&
    otp_cnt[row1[4:0]] == OTP_NOP_MAX |=> err[1] && !busy)
    else $error("ninth OTP partial program not refused");
  a_lock_addr: assert property (
    launch && !busy && prot_bad |=> err[2] && !busy)
    else $error("OTP lock with nonzero address not refused");
  a_plane_select: assert property (
    launch && !busy && close && row1[6] == arm_pl |=> err[3] && !busy)
    else $error("same plane bit accepted in two-plane pair");
  a_pair_arm: assert property (
    go && arm |=> armed && arm_pl == $past(row1[6]))
    else $error("first plane of pair not recorded");

  // Pin sequencer; strobes default inactive every cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
      ph <= 1'b0;
      cnt <= 3'd0;
      idx <= 3'd0;
      busy <= 1'b0;
      rdata <= RST_WORD;
      stat_byte <= 8'h00;
      nand_ce_n <= 1'b1;
      nand_cle <= 1'b0;
      nand_ale <= 1'b0;
      nand_we_n <= 1'b1;
      nand_re_n <= 1'b1;
      nand_io_out <= 8'h00;
      nand_io_oe <= 1'b0;
    end else begin
      nand_cle <= 1'b0;
      nand_ale <= 1'b0;
      nand_we_n <= 1'b1;
      nand_re_n <= 1'b1;
      case (state)
        S_IDLE: if (go) begin
          busy <= 1'b1;
          nand_ce_n <= 1'b0;
          idx <= 3'd0;
          cnt <= 3'd0;
          ph <= 1'b0;
          state <= S_CMD1;
        end
        S_CMD1: if (!c.has1) begin
          state <= S_ADDR;
        end else if (!ph) begin
          nand_cle <= 1'b1;
          nand_we_n <= 1'b0;
          nand_io_out <= c.cmd1;
          nand_io_oe <= 1'b1;
          ph <= 1'b1;
        end else begin
          nand_cle <= 1'b1;
          ph <= 1'b0;
          state <= S_ADDR;
        end
        S_ADDR: if (idx == c.ac) begin
          idx <= 3'd0;
          state <= S_WDAT;
        end else if (!ph) begin
          nand_ale <= 1'b1;
          nand_we_n <= 1'b0;
          nand_io_out <= a_sh[7:0];
          nand_io_oe <= 1'b1;
          ph <= 1'b1;
        end else begin
          nand_ale <= 1'b1;
          ph <= 1'b0;
          idx <= idx + 3'd1;
        end
        S_WDAT: if (c.dir || idx == c.dc) begin
          idx <= 3'd0;
          cnt <= 3'd0;
          state <= S_CMD2;
        end else if (idx == 3'd0 && cnt < ADL_CYC) begin
          cnt <= cnt + 3'd1;
        end else if (!ph) begin
          nand_we_n <= 1'b0;
          nand_io_out <= w_sh[7:0];
          nand_io_oe <= 1'b1;
          ph <= 1'b1;
        end else begin
          ph <= 1'b0;
          idx <= idx + 3'd1;
        end
        S_CMD2: if (!c.has2) begin
          state <= S_WB;
        end else if (!ph) begin
          nand_cle <= 1'b1;
          nand_we_n <= 1'b0;
          nand_io_out <= c.cmd2;
          nand_io_oe <= 1'b1;
          ph <= 1'b1;
        end else begin
          nand_cle <= 1'b1;
          ph <= 1'b0;
          state <= S_WB;
        end
        S_WB: if (!c.wait_busy) begin
          state <= S_RDAT;
        end else if (cnt < WB_CYC) begin
          cnt <= cnt + 3'd1;
        end else begin
          cnt <= 3'd0;
          state <= use_poll ? S_PCMD : S_WRB;
        end
        // Pin busy stays low until the device finishes
        S_WRB: if (rb_s) state <= S_RDAT;
        S_PCMD: if (!ph) begin
          nand_cle <= 1'b1;
          nand_we_n <= 1'b0;
          nand_io_out <= CMD_STATUS;
          nand_io_oe <= 1'b1;
          ph <= 1'b1;
        end else begin
          nand_cle <= 1'b1;
          ph <= 1'b0;
          cnt <= 3'd0;
          state <= S_PRD;
        end
        S_PRD: begin
          nand_io_oe <= 1'b0;
          if (!ph && cnt == RD_CYC) begin
            stat_byte <= io_s;
            ph <= 1'b1;
          end else if (!ph) begin
            nand_re_n <= 1'b0;
            cnt <= cnt + 3'd1;
          end else begin
            ph <= 1'b0;
            cnt <= 3'd0;
            if (stat_byte[SR_READY_BIT])
              state <= S_RESUME;
          end
        end
        // Status mode hides data until a read opcode re-enables it
        S_RESUME: if (!want_rd) begin
          state <= S_DONE;
        end else if (!ph) begin
          nand_cle <= 1'b1;
          nand_we_n <= 1'b0;
          nand_io_out <= CMD_READ;
          nand_io_oe <= 1'b1;
          ph <= 1'b1;
        end else begin
          nand_cle <= 1'b1;
          ph <= 1'b0;
          state <= S_RDAT;
        end
        S_RDAT: begin
          nand_io_oe <= 1'b0;
          if (!c.dir || idx == c.dc) begin
            state <= S_DONE;
          end else if (!ph && cnt == RD_CYC) begin
            rdata[{idx[1:0], 3'b000} +: 8] <= io_s;
            ph <= 1'b1;
          end else if (!ph) begin
            nand_re_n <= 1'b0;
            cnt <= cnt + 3'd1;
          end else begin
            ph <= 1'b0;
            cnt <= 3'd0;
            idx <= idx + 3'd1;
          end
        end
        S_DONE: begin
          nand_ce_n <= 1'b1;
          nand_io_oe <= 1'b0;
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  a_feat_write_op: assert property (
    go && c.has1 && c.cmd1 == CMD_SET_FEAT |-> ##2
    s_cmd_cycle(CMD_SET_FEAT) ##1 (nand_cle && nand_we_n))
    else $error("feature write did not open with EFh");
  a_feat_read_op: assert property (
    go && c.has1 && c.cmd1 == CMD_GET_FEAT |-> ##2
    s_cmd_cycle(CMD_GET_FEAT))
    else $error("feature read did not open with EEh");
  a_resume_read: assert property (
    state == S_RESUME && !ph && want_rd |-> ##1
    s_cmd_cycle(CMD_READ) ##1 (nand_cle && nand_we_n))
    else $error("read opcode not issued after status poll");
endmodule
`default_nettype wire

// [verif/nfc_flash_model.sv]
// Behavioural NAND flash device seen from the host pins
`timescale 1ns/10ps
`default_nettype none
module nfc_flash_model #(
  parameter int BUSY_CYC = 20
) (
  // Timing reference for busy spans
  input wire logic clock,
  // Control pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  output logic rb_n,
  // Data bus
  input wire logic [7:0] io_in,
  output logic [7:0] io_out
);
  logic [7:0] array_operation_mode = 8'h00;
  logic [7:0] cur = 8'h00;
  logic [7:0] fa = 8'h00;
  logic [7:0] dq = 8'h00;
  logic [7:0] adr [5];
  logic [7:0] prm [4];
  logic otp_locked = 1'b0;
  logic st_out = 1'b0;
  int busy = 0;
  int na = 0;
  int nd = 0;
  int idx = 0;
  int otp_cnt [32];
  logic [7:0] cmds [$];

  assign rb_n = (busy == 0);
  // Released bus shows the inverse so stale data never passes
  assign io_out = (!ce_n && !re_n) ? dq : ~dq;

  always @(posedge clock)
    if (busy > 0) busy = busy - 1;

  task automatic program_done();
    logic [4:0] pg;
    pg = (na == 3) ? adr[0][4:0] : adr[2][4:0];
    if (array_operation_mode == 8'h03) otp_locked = 1'b1;
    else if (array_operation_mode == 8'h01 && !otp_locked)
      otp_cnt[pg]++;
  endtask

  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmds.push_back(io_in);
      case (io_in)
        8'h70: st_out = 1'b1;
        8'h00: st_out = 1'b0;
        // Column change keeps the open page and its row address
        8'h05, 8'hE0, 8'h85: na = 0;
        8'h10, 8'h11, 8'h15, 8'hD0, 8'hD1: begin
          busy = BUSY_CYC;
          if (io_in == 8'h10 && cur == 8'h80) program_done();
        end
        default: begin
          cur = io_in;
          na = 0;
          nd = 0;
          st_out = 1'b0;
          // Reset command leaves features alone
          if (io_in == 8'hFF) busy = BUSY_CYC;
        end
      endcase
    end else if (!ce_n && ale && na < 5) begin
      adr[na] = io_in;
      na++;
      fa = io_in;
      if (cur == 8'hEE) begin
        busy = BUSY_CYC;
        idx = 0;
      end
    end else if (!ce_n && !ale && cur == 8'hEF && nd < 4) begin
      prm[nd] = io_in;
      nd++;
      if (nd == 4) begin
        if (fa == 8'h90) array_operation_mode = prm[0];
        busy = BUSY_CYC;
      end
    end
  end

  always @(negedge re_n)
    if (!ce_n) begin
      if (st_out) dq = {1'b1, rb_n, 6'h00};
      else if (cur == 8'hEE) begin
        dq = (idx == 0 && fa == 8'h90) ? array_operation_mode : 8'h00;
        idx++;
      end
    end
endmodule
`default_nettype wire

// [verif/nfc_top_bench.sv]
// Self-checking bench for the NAND host sequencer
`timescale 1ns/10ps
`default_nettype none
module nfc_top_bench
  import nfc_pkg::*;
;
  logic clock, sys_rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic nand_ce_n, nand_cle, nand_ale, nand_we_n, nand_re_n, nand_rb_n;
  logic [7:0] nand_io_out, nand_io_in, dev_out;
  logic nand_io_oe;
  int fail_count = 0;
  int checks_done = 0;
  int n0;

  assign nand_io_in = nand_io_oe ? nand_io_out : dev_out;

  nfc_top nfc_top_inst(.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .nand_ce_n, .nand_cle, .nand_ale,
    .nand_we_n, .nand_re_n, .nand_rb_n, .nand_io_out, .nand_io_oe,
    .nand_io_in);

  nfc_flash_model nfc_flash_model_inst(.clock, .ce_n(nand_ce_n),
    .cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n), .re_n(nand_re_n),
    .rb_n(nand_rb_n), .io_in(nand_io_in), .io_out(dev_out));

  always #20 clock = ~clock;

  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", nm, exp, got);
      fail_count++;
    end
  endtask

  // Idle cycle after each transfer keeps drivers to one change per step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [31:0] cw(input logic [7:0] c1, c2,
      input logic [2:0] ac, dc, input logic [4:0] fl);
    return {5'h00, fl, dc, ac, c2, c1};
  endfunction

  task automatic op(input logic [31:0] c, a0, a1, wd);
    apb(1'b1, REG_ADDR0, a0);
    apb(1'b1, REG_ADDR1, a1);
    apb(1'b1, REG_WDATA, wd);
    apb(1'b1, REG_CMD, c);
    repeat (4) @(posedge clock);
    do begin
      apb(1'b0, REG_STAT, 32'h0000_0000);
    end while (rd[0] !== 1'b0);
  endtask

  task automatic set_feat(input logic [7:0] p1);
    op(cw(CMD_SET_FEAT, 8'h00, 3'h1, 3'h4, 5'h06), 32'h0000_0090,
       32'h0000_0000, {24'h00_0000, p1});
  endtask

  task automatic get_feat(input logic [4:0] fl, input logic [7:0] exp);
    op(cw(CMD_GET_FEAT, 8'h00, 3'h1, 3'h4, fl), 32'h0000_0090,
       32'h0000_0000, 32'h0000_0000);
    apb(1'b0, REG_RDATA, 32'h0000_0000);
    chk("get feature", {24'h00_0000, exp}, rd);
  endtask

  task automatic stat_chk(input logic [3:0] err, input logic [7:0] md);
    apb(1'b0, REG_STAT, 32'h0000_0000);
    chk("errors", {28'h000_0000, err}, {28'h000_0000, rd[19:16]});
    chk("mode shadow", {24'h00_0000, md}, {24'h00_0000, rd[15:8]});
  endtask

  task automatic t_reset();
    apb(1'b0, REG_STAT, 32'h0000_0000);
    chk("stat reset", 32'h0000_0000, rd);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, er});
    chk("unmapped", 32'h0000_0000, rd);
    $display("test reset done");
  endtask

  task automatic t_feature();
    n0 = nfc_flash_model_inst.cmds.size();
    set_feat(MODE_OTP);
    chk("first cmd", 32'hEF, nfc_flash_model_inst.cmds[n0]);
    chk("done poll", 32'h70, nfc_flash_model_inst.cmds[$]);
    chk("dev mode", 32'h01, nfc_flash_model_inst.array_operation_mode);
    stat_chk(4'h0, MODE_OTP);
    chk("last status", 32'hC0, {24'h00_0000, rd[31:24]});
    get_feat(5'h17, MODE_OTP);
    chk("reenable", 32'h00, nfc_flash_model_inst.cmds[$]);
    op(cw(8'hFF, 8'h00, 3'h0, 3'h0, 5'h06), 0, 0, 0);
    get_feat(5'h07, MODE_OTP);
    $display("test feature done");
  endtask

  task automatic t_otp();
    n0 = nfc_flash_model_inst.cmds.size();
    op(cw(CMD_PROG, CMD_PROG_GO, 3'h5, 3'h1, 5'h0E), 32'h0001_0000, 0, 0);
    stat_chk(4'h2, MODE_OTP);
    chk("no pins", n0, nfc_flash_model_inst.cmds.size());
    for (int i = 1; i <= 8; i++) begin
      op(cw(CMD_PROG, CMD_PROG_GO, 3'h5, 3'h1, 5'h0E), 32'h0002_0000, 0, 0);
      chk("otp prog", i, nfc_flash_model_inst.otp_cnt[2]);
    end
    op(cw(CMD_PROG, CMD_PROG_GO, 3'h5, 3'h1, 5'h0E), 32'h0002_0000, 0, 0);
    stat_chk(4'h2, MODE_OTP);
    chk("otp ninth", 8, nfc_flash_model_inst.otp_cnt[2]);
    op(cw(CMD_PROG, 8'h85, 3'h5, 3'h1, 5'h0C), 32'h0004_0000, 0, 0);
    op(cw(8'h00, CMD_PROG_GO, 3'h2, 3'h1, 5'h0A), 0, 0, 0);
    chk("otp random in", 1, nfc_flash_model_inst.otp_cnt[4]);
    $display("test otp done");
  endtask

  task automatic t_lock();
    set_feat(MODE_OTP_PROT);
    op(cw(CMD_PROG, CMD_PROG_GO, 3'h5, 3'h1, 5'h0E), 0, 32'h01, 0);
    stat_chk(4'h4, MODE_OTP_PROT);
    op(cw(CMD_PROG, CMD_PROG_GO, 3'h5, 3'h1, 5'h0E), 0, 0, 0);
    chk("locked", 1, nfc_flash_model_inst.otp_locked);
    apb(1'b0, REG_STAT, 32'h0000_0000);
    chk("lock flag", 1, rd[2]);
    set_feat(MODE_OTP);
    op(cw(CMD_PROG, CMD_PROG_GO, 3'h5, 3'h1, 5'h0E), 32'h0003_0000, 0, 0);
    stat_chk(4'h2, MODE_OTP);
    set_feat(MODE_NORMAL);
    stat_chk(4'h0, MODE_NORMAL);
    set_feat(8'h02);
    stat_chk(4'h1, MODE_NORMAL);
    chk("dev mode", 0, nfc_flash_model_inst.array_operation_mode);
    $display("test lock done");
  endtask

  task automatic t_plane();
    n0 = nfc_flash_model_inst.cmds.size();
    op(cw(8'h60, CMD_ERASE_NEXT, 3'h3, 3'h0, 5'h0E), 32'h40, 0, 0);
    op(cw(8'h60, CMD_ERASE_GO, 3'h3, 3'h0, 5'h0E), 32'h00, 0, 0);
    stat_chk(4'h0, MODE_NORMAL);
    chk("erase 1", 32'hD1, nfc_flash_model_inst.cmds[n0 + 1]);
    chk("erase 2", 32'hD0, nfc_flash_model_inst.cmds[n0 + 3]);
    n0 = nfc_flash_model_inst.cmds.size();
    op(cw(CMD_PROG, CMD_PLANE_NEXT, 3'h5, 3'h1, 5'h0E), 32'h0045_0000, 0, 0);
    op(cw(CMD_PROG, CMD_PROG_GO, 3'h5, 3'h1, 5'h0E), 32'h0105_0000, 0, 0);
    stat_chk(4'h0, MODE_NORMAL);
    chk("prog 1", 32'h11, nfc_flash_model_inst.cmds[n0 + 1]);
    chk("prog 2", 32'h10, nfc_flash_model_inst.cmds[n0 + 3]);
    op(cw(8'h60, CMD_ERASE_NEXT, 3'h3, 3'h0, 5'h0E), 32'h00, 0, 0);
    op(cw(8'h60, CMD_ERASE_GO, 3'h3, 3'h0, 5'h0E), 32'h01, 0, 0);
    stat_chk(4'h8, MODE_NORMAL);
    $display("test plane done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run needs well under a quarter of this span
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    end_sim();
  end

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_feature();
    t_otp();
    t_lock();
    t_plane();
    end_sim();
  end
endmodule
`default_nettype wire
